// file: rtl/kwg_pkg.sv
package kwg_pkg;

   // Software access strobe bundle seen by the watchdog.
   typedef struct packed {
      logic mode_wr;
      logic key_wr;
      logic key_bit_op;
      logic [7:0] wdata;
   } kwg_acc_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_STOP = 3'b010,
      ST_OVF = 3'b100
   } kwg_state_t;

   localparam logic [7:0] KWG_STOP_CODE = 8'h1F;
   localparam logic [7:0] KWG_KEY_CODE = 8'hAC;
   localparam logic [7:0] KWG_KEY_READ = 8'h9A;
   // Reset mode value: overflow requests a reset (bit 6 low) and the longest interval is selected.
   localparam logic [7:0] KWG_MODE_RESET = 8'h27;
   localparam int KWG_MODE_NMI_BIT = 6;
   localparam int KWG_SEL_LSB = 0;
   localparam int KWG_SEL_W = 3;
   localparam int KWG_CNT_W = 25;
   localparam int KWG_SHIFT_MIN = 18;
   localparam int KWG_SHIFT_MAX = 25;
   localparam int KWG_OVF_PULSE_CYC = 1;

endpackage

// file: rtl/kwg_prescaler.sv
`timescale 1ns/1ps
module kwg_prescaler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic [2:0] sel_i,
   output logic expire_o
);
   logic [kwg_pkg::KWG_CNT_W-1:0] cnt_r;
   logic [kwg_pkg::KWG_CNT_W-1:0] cnt_nxt;
   logic [kwg_pkg::KWG_CNT_W-1:0] limit;

   // Interval is the clock divided by 2^(18+sel), so sel 7 gives 2^25.
   always_comb begin
      limit = {kwg_pkg::KWG_CNT_W{1'b1}}
         >> (kwg_pkg::KWG_SHIFT_MAX - kwg_pkg::KWG_SHIFT_MIN - int'(sel_i));
      cnt_nxt = cnt_r;
      if (clear_i) begin
         cnt_nxt = '0;
      end else if (run_i) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   assign expire_o = run_i && !clear_i && (cnt_r == limit);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// file: rtl/kwg_watchdog.sv
`timescale 1ns/1ps
// How it works
// - Writing the stop code as the first mode register write after reset halts counting.
// - While counting, a second mode register write after reset forces overflow.
// - While counting, a key write other than the valid key forces overflow.
// - While counting, a single-bit manipulation of the key register forces overflow.
// - Key register reads always return a fixed non-key constant.
// - When stopped, misuse of either register raises no overflow.
// - After reset the watchdog runs in reset mode at the longest interval.
module kwg_watchdog (
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic RST_I,
   // Software access.
   input wire kwg_pkg::kwg_acc_t ACC_I,
   // Observed state.
   output logic [7:0] KEY_RDATA_O,
   output logic [7:0] MODE_O,
   output logic RUNNING_O,
   // Overflow results.
   output logic RESET_REQ_O,
   output logic WDT_NMI_REQUEST_O
);
   kwg_pkg::kwg_state_t state_r, state_nxt;
   logic [7:0] wdt_mode_reg_r, wdt_mode_reg_nxt;
   logic mode_written_r, mode_written_nxt;
   logic rst_req_r, rst_req_nxt;
   logic nmi_r, nmi_nxt;
   logic running_r, running_nxt;
   logic [7:0] key_rdata_r, key_rdata_nxt;
   logic clear, expire, misuse, ovf;

   kwg_prescaler u_pre (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .clear_i(clear),
      .run_i(state_r == kwg_pkg::ST_RUN),
      .sel_i(wdt_mode_reg_r[kwg_pkg::KWG_SEL_LSB +: kwg_pkg::KWG_SEL_W]),
      .expire_o(expire)
   );

   always_comb begin
      state_nxt = state_r;
      wdt_mode_reg_nxt = wdt_mode_reg_r;
      mode_written_nxt = mode_written_r;
      clear = 1'b0;
      misuse = 1'b0;
      if (ACC_I.mode_wr) begin
         if (mode_written_r) begin
            misuse = 1'b1;
         end else begin
            mode_written_nxt = 1'b1;
            wdt_mode_reg_nxt = ACC_I.wdata;
            clear = 1'b1;
         end
      end
      if (ACC_I.key_wr) begin
         if (ACC_I.key_bit_op || ACC_I.wdata != kwg_pkg::KWG_KEY_CODE) begin
            misuse = 1'b1;
         end else begin
            clear = 1'b1;
         end
      end
      ovf = (state_r == kwg_pkg::ST_RUN) && (misuse || expire);
      case (state_r)
         kwg_pkg::ST_RUN: begin
            if (ovf) begin
               state_nxt = kwg_pkg::ST_OVF;
            end else if (wdt_mode_reg_nxt == kwg_pkg::KWG_STOP_CODE) begin
               state_nxt = kwg_pkg::ST_STOP;
            end
         end
         kwg_pkg::ST_STOP: state_nxt = kwg_pkg::ST_STOP;
         kwg_pkg::ST_OVF: begin
            // A stop code that arrives with or right after an overflow still takes effect.
            if (wdt_mode_reg_nxt == kwg_pkg::KWG_STOP_CODE) begin
               state_nxt = kwg_pkg::ST_STOP;
            end else begin
               state_nxt = kwg_pkg::ST_RUN;
            end
         end
         default: state_nxt = kwg_pkg::ST_RUN;
      endcase
      // Overflow is a one-cycle pulse, then counting resumes from zero.
      if (state_r == kwg_pkg::ST_OVF) begin
         clear = 1'b1;
      end
      rst_req_nxt = ovf && !wdt_mode_reg_r[kwg_pkg::KWG_MODE_NMI_BIT];
      nmi_nxt = ovf && wdt_mode_reg_r[kwg_pkg::KWG_MODE_NMI_BIT];
      running_nxt = (state_nxt != kwg_pkg::ST_STOP)
         && (wdt_mode_reg_nxt != kwg_pkg::KWG_STOP_CODE);
      key_rdata_nxt = kwg_pkg::KWG_KEY_READ;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_r <= kwg_pkg::ST_RUN;
         wdt_mode_reg_r <= kwg_pkg::KWG_MODE_RESET;
         mode_written_r <= 1'b0;
         rst_req_r <= 1'b0;
         nmi_r <= 1'b0;
         running_r <= 1'b1;
         key_rdata_r <= kwg_pkg::KWG_KEY_READ;
      end else begin
         state_r <= state_nxt;
         wdt_mode_reg_r <= wdt_mode_reg_nxt;
         mode_written_r <= mode_written_nxt;
         rst_req_r <= rst_req_nxt;
         nmi_r <= nmi_nxt;
         running_r <= running_nxt;
         key_rdata_r <= key_rdata_nxt;
      end
   end

   assign KEY_RDATA_O = key_rdata_r;
   assign MODE_O = wdt_mode_reg_r;
   assign RUNNING_O = running_r;
   assign RESET_REQ_O = rst_req_r;
   assign WDT_NMI_REQUEST_O = nmi_r;
endmodule

// file: tb/kwg_watchdog_asserts.sv
`timescale 1ns/1ps
module kwg_watchdog_asserts (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire kwg_pkg::kwg_acc_t ACC_I,
   input wire logic [7:0] KEY_RDATA_O,
   input wire logic [7:0] MODE_O,
   input wire logic RUNNING_O,
   input wire logic RESET_REQ_O,
   input wire logic WDT_NMI_REQUEST_O
);
   logic w_r;
   wire o = RESET_REQ_O | WDT_NMI_REQUEST_O;
   wire k = ACC_I.key_wr & RUNNING_O & ~o;
   always_ff @(posedge CLK_I) w_r <= !RST_I && (w_r || ACC_I.mode_wr);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   chk_stop_halts: assert property (MODE_O == kwg_pkg::KWG_STOP_CODE |-> !RUNNING_O)
      else $error("runs");
   chk_twice_ovf: assert property (ACC_I.mode_wr && w_r && RUNNING_O && !o |=> o)
      else $error("no overflow");
   chk_bad_key: assert property (k && ACC_I.wdata != kwg_pkg::KWG_KEY_CODE |=> o)
      else $error("bad key");
   chk_bit_op: assert property (k && ACC_I.key_bit_op |=> o) else $error("bit op");
   chk_key_read: assert property (KEY_RDATA_O == kwg_pkg::KWG_KEY_READ)
      else $error("key read");
   chk_stop_quiet: assert property (!RUNNING_O |=> !o) else $error("stopped");
   chk_reset_mode: assert property ($fell(RST_I) |-> MODE_O == kwg_pkg::KWG_MODE_RESET && RUNNING_O)
      else $error("reset mode");
   chk_good_key: assert property (k && ACC_I.wdata == kwg_pkg::KWG_KEY_CODE && !ACC_I.key_bit_op
      && !ACC_I.mode_wr |=> !o) else $error("good key");
endmodule
bind kwg_watchdog kwg_watchdog_asserts u_chk (
   .CLK_I(CLK_I),
   .RST_I(RST_I),
   .ACC_I(ACC_I),
   .KEY_RDATA_O(KEY_RDATA_O),
   .MODE_O(MODE_O),
   .RUNNING_O(RUNNING_O),
   .RESET_REQ_O(RESET_REQ_O),
   .WDT_NMI_REQUEST_O(WDT_NMI_REQUEST_O)
);

// file: tb/kwg_watchdog_test.sv
`timescale 1ns/1ps
module kwg_watchdog_test;
   logic clk = 1'b0, rst = 1'b1;
   kwg_pkg::kwg_acc_t acc = '0;
   logic rq, nq;
   logic [7:0] kr, md;
   logic rn;
   int mismatches = 0, cmp_count = 0;
   always #2.5 clk = ~clk;
   kwg_watchdog dut (.CLK_I(clk), .RST_I(rst), .ACC_I(acc), .KEY_RDATA_O(kr), .MODE_O(md),
      .RUNNING_O(rn), .RESET_REQ_O(rq), .WDT_NMI_REQUEST_O(nq));
   // Settled view of the mode register, the run flag and the key read value.
   task look(input logic [7:0] m, input logic r);
      #1;
      cmp_count += 3;
      if (md !== m) begin
         $display("ERROR mode exp %h got %h", m, md);
         mismatches++;
      end
      if (rn !== r) begin
         $display("ERROR running exp %h got %h", r, rn);
         mismatches++;
      end
      if (kr !== kwg_pkg::KWG_KEY_READ) begin
         $display("ERROR key read exp %h got %h", kwg_pkg::KWG_KEY_READ, kr);
         mismatches++;
      end
   endtask
   // One access cycle, then the overflow pair is judged in the cycle after it.
   task put(input logic [2:0] s, input logic [7:0] d, input logic [1:0] e);
      @(posedge clk);
      acc <= {s, d};
      @(posedge clk);
      acc <= '0;
      #1;
      cmp_count++;
      if ({nq, rq} !== e) $display("ERROR pulse after %h %h exp %h got %h", s, d, e, {nq, rq});
      if ({nq, rq} !== e) mismatches++;
   endtask
   task t_key;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      look(kwg_pkg::KWG_MODE_RESET, 1'b1);
      put(3'h2, 8'hAC, 2'h0);
      put(3'h2, 8'h00, 2'h1);
      put(3'h3, 8'hAC, 2'h1);
      put(3'h4, 8'h40, 2'h0);
      look(8'h40, 1'b1);
      put(3'h4, 8'h41, 2'h2);
      look(8'h40, 1'b1);
   endtask
   task t_stop;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      look(kwg_pkg::KWG_MODE_RESET, 1'b1);
      put(3'h4, 8'h1F, 2'h0);
      look(kwg_pkg::KWG_STOP_CODE, 1'b0);
      put(3'h2, 8'h00, 2'h0);
      put(3'h4, 8'h1F, 2'h0);
      put(3'h3, 8'hAC, 2'h0);
      look(kwg_pkg::KWG_STOP_CODE, 1'b0);
   endtask
   task print_verdict;
      $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      t_key();
      t_stop();
      print_verdict();
   end
endmodule
